// File: rtl/glc_pkg.sv
package glc_pkg;

    // Register map
    localparam logic [5:0] GLC_ADDR_CTRL = 6'h1D;     // Gain loop control offset
    localparam logic [7:0] GLC_CTRL_RESET = 8'h91;    // 10 01 00 01 after reset

    // Field positions in the control byte
    localparam int GLC_HYST_LSB = 6;                  // Hysteresis select 7:6
    localparam int GLC_WAIT_LSB = 4;                  // Settle wait 5:4
    localparam int GLC_HOLD_LSB = 2;                  // Gain hold select 3:2
    localparam int GLC_FILT_LSB = 0;                  // Filter length 1:0

    // Timing counts, in channel filter samples; OOK boundary step in dB
    localparam logic [5:0] GLC_WAIT_STEP = 6'h08;     // 8, 16, 24, 32 samples
    localparam int GLC_FILT_BASE_LOG2 = 3;            // 8 samples at code 0
    localparam logic [7:0] GLC_OOK_STEP_DB = 8'h04;   // 4, 8, 12, 16 dB

    // Dead zone edges per hysteresis code, in amplitude units (dB)
    localparam logic [7:0] GLC_ZONE_HI [4] = '{8'h02, 8'h02, 8'h04, 8'h06};
    localparam logic [7:0] GLC_ZONE_LO [4] = '{8'h02, 8'h04, 8'h08, 8'h0C};

    // Gain hold policies
    typedef enum logic [1:0] {
        GLC_HOLD_NONE = 2'h0,                         // Adjust freely
        GLC_HOLD_SYNC = 2'h1,                         // Freeze after sync word
        GLC_HOLD_ANA  = 2'h2,                         // Analogue fixed
        GLC_HOLD_ALL  = 2'h3                          // Everything fixed
    } glc_hold_type;

    // Decoded control byte
    typedef struct packed {
        logic [1:0] hysteresis_select;                // Dead zone choice
        logic [1:0] wait_select;                      // Settle wait length
        glc_hold_type gain_hold_select;               // Freeze policy
        logic [1:0] filter_select;                    // Averaging / OOK boundary
    } glc_ctrl_type;

endpackage : glc_pkg

// File: rtl/glc_averager.sv
`timescale 1ns/1ps
// Block averager over 8..64 samples; power-of-two length so a shift divides
module glc_averager #(
    parameter int AMP_W = 8                           // Amplitude width
) (
    input wire logic clk_i,                           // Core clock
    input wire logic rst_n_i,                         // Synchronised reset
    input wire logic clear_i,                         // Restart accumulation
    input wire logic enable_i,                        // Accumulate allowed
    input wire logic sample_vld_i,                    // New filter sample
    input wire logic [AMP_W-1:0] sample_i,            // Filter amplitude
    input wire logic [1:0] length_sel_i,              // 8/16/32/64 samples
    output logic done_o,                              // One-cycle average ready
    output logic [AMP_W-1:0] avg_o                    // Last average
);

    localparam int SUM_W = AMP_W + 6;                 // Room for 64 samples

    logic [SUM_W-1:0] sum_r;                          // Running sum
    logic [6:0] count_r;                              // Samples taken
    logic [6:0] target;                               // Samples needed
    logic [SUM_W-1:0] sum_nxt;                        // Sum with new sample
    logic [SUM_W-1:0] shifted;                        // Divided sum

    assign target = 7'(1 << (glc_pkg::GLC_FILT_BASE_LOG2 + int'(length_sel_i)));
    assign sum_nxt = sum_r + SUM_W'(sample_i);
    assign shifted = sum_nxt >> (glc_pkg::GLC_FILT_BASE_LOG2 + int'(length_sel_i));

    ////////////////////////////////////////////////////////////////////////////
    // Accumulate, then emit the average and restart
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sum_r <= '0;
            count_r <= '0;
            done_o <= 1'b0;
            avg_o <= '0;
        end else begin
            done_o <= 1'b0;
            if (clear_i) begin                        // Gain moved, old data stale
                sum_r <= '0;
                count_r <= '0;
            end else if (enable_i && sample_vld_i) begin
                if (count_r + 7'h01 >= target) begin  // Window complete
                    avg_o <= AMP_W'(shifted);
                    done_o <= 1'b1;
                    sum_r <= '0;
                    count_r <= '0;
                end else begin
                    sum_r <= sum_nxt;
                    count_r <= count_r + 7'h01;
                end
            end
        end
    end

endmodule : glc_averager

// File: rtl/glc_gain_loop.sv
`timescale 1ns/1ps
module glc_gain_loop #(
    parameter int AMP_W = 8,                          // Amplitude width
    parameter int ANA_W = 3,                          // Analogue gain steps width
    parameter int DIG_W = 3,                          // Digital gain steps width
    parameter logic [7:0] MAGN_TARGET = 8'h21         // Desired amplitude
) (
    input wire logic CLK_I,                           // 250 MHz core clock
    input wire logic RST_N_I,                         // Async reset, active low
    input wire logic REG_WE_I,                        // Register write strobe
    input wire logic [5:0] REG_ADDR_I,                // Register address
    input wire logic [7:0] REG_WDATA_I,               // Register write data
    output logic [7:0] REG_RDATA_O,                   // Register read data
    input wire logic SAMPLE_VLD_I,                    // Channel filter sample strobe
    input wire logic [AMP_W-1:0] SAMPLE_I,            // Channel filter amplitude
    input wire logic SYNC_FOUND_I,                    // Sync word detected pulse
    input wire logic RX_IDLE_I,                       // Receiver idle level
    input wire logic OOK_MODE_I,                      // OOK/ASK reception selected
    output logic [ANA_W-1:0] ANA_GAIN_O,              // Analogue gain setting
    output logic [DIG_W-1:0] DIG_GAIN_O,              // Digital gain setting
    output logic [AMP_W-1:0] AMP_AVG_O,               // Latest averaged amplitude
    output logic SETTLING_O,                          // Waiting after a gain step
    output logic OOK_BIT_O                            // OOK/ASK data decision
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    typedef enum logic {
        ST_SETTLE,                                    // Ignoring samples after a step
        ST_ACCUM                                      // Averaging for a decision
    } glc_state_type;

    logic rst_meta_r;                                 // Reset sync stage 1
    logic rst_n_s;                                    // Reset sync stage 2
    glc_pkg::glc_ctrl_type ctrl_r;                    // Stored control byte
    glc_pkg::glc_ctrl_type act_r;                     // Settings of current decision
    glc_state_type state_r;                           // Loop state
    logic [5:0] wait_cnt_r;                           // Samples waited
    logic [5:0] wait_target;                          // Samples to wait
    logic sync_seen_r;                                // Sync word caught this packet
    logic avg_done;                                   // Average ready pulse
    logic [AMP_W-1:0] avg;                            // Average value
    logic [7:0] zone_hi;                              // Upper dead zone edge
    logic [7:0] zone_lo;                              // Lower dead zone edge
    logic too_loud;                                   // Above dead zone
    logic too_quiet;                                  // Below dead zone
    logic hold_all;                                   // No gain may move
    logic hold_ana;                                   // Analogue may not move
    logic step_made;                                  // A gain changed
    logic [ANA_W-1:0] ana_nxt;                        // Next analogue gain
    logic [DIG_W-1:0] dig_nxt;                        // Next digital gain
    logic [8:0] ook_thr;                              // OOK slicing level
    logic [7:0] ook_db;                               // OOK boundary in dB

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_r <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_s <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register write; host is expected to write only while idle
    always_ff @(posedge CLK_I or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl_r <= glc_pkg::GLC_CTRL_RESET;
        end else if (REG_WE_I && REG_ADDR_I == glc_pkg::GLC_ADDR_CTRL) begin
            ctrl_r <= REG_WDATA_I;
        end
    end

    // Registered readback; other addresses answer zero
    always_ff @(posedge CLK_I or negedge rst_n_s) begin
        if (!rst_n_s) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_ADDR_I == glc_pkg::GLC_ADDR_CTRL) begin
            REG_RDATA_O <= ctrl_r;
        end else begin
            REG_RDATA_O <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync word latch; a new sync in the idle cycle still wins
    always_ff @(posedge CLK_I or negedge rst_n_s) begin
        if (!rst_n_s) begin
            sync_seen_r <= 1'b0;
        end else if (SYNC_FOUND_I) begin
            sync_seen_r <= 1'b1;
        end else if (RX_IDLE_I) begin
            sync_seen_r <= 1'b0;                      // Packet over, unfreeze
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Amplitude averaging
    glc_averager #(
        .AMP_W(AMP_W)
    ) u_avg (
        .clk_i(CLK_I),
        .rst_n_i(rst_n_s),
        .clear_i(state_r == ST_SETTLE),
        .enable_i(state_r == ST_ACCUM),
        .sample_vld_i(SAMPLE_VLD_I),
        .sample_i(SAMPLE_I),
        .length_sel_i(act_r.filter_select),
        .done_o(avg_done),
        .avg_o(avg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Gain decision against the dead zone
    assign zone_hi = glc_pkg::GLC_ZONE_HI[act_r.hysteresis_select];
    assign zone_lo = glc_pkg::GLC_ZONE_LO[act_r.hysteresis_select];
    assign too_loud = {1'b0, 8'(avg)} > ({1'b0, MAGN_TARGET} + {1'b0, zone_hi});
    assign too_quiet = {1'b0, 8'(avg)} + {1'b0, zone_lo} < {1'b0, MAGN_TARGET};

    assign hold_all = act_r.gain_hold_select == glc_pkg::GLC_HOLD_ALL
        || (act_r.gain_hold_select == glc_pkg::GLC_HOLD_SYNC && sync_seen_r);
    assign hold_ana = act_r.gain_hold_select == glc_pkg::GLC_HOLD_ANA;

    // Analogue steps first, digital trims once analogue is pinned or held
    always_comb begin
        ana_nxt = ANA_GAIN_O;
        dig_nxt = DIG_GAIN_O;
        if (!hold_all) begin
            if (too_loud) begin
                if (!hold_ana && ANA_GAIN_O != '0) begin
                    ana_nxt = ANA_GAIN_O - ANA_W'(1);
                end else if (DIG_GAIN_O != '0) begin
                    dig_nxt = DIG_GAIN_O - DIG_W'(1);
                end
            end else if (too_quiet) begin
                if (!hold_ana && ANA_GAIN_O != '1) begin
                    ana_nxt = ANA_GAIN_O + ANA_W'(1);
                end else if (DIG_GAIN_O != '1) begin
                    dig_nxt = DIG_GAIN_O + DIG_W'(1);
                end
            end
        end
    end

    assign step_made = (ana_nxt != ANA_GAIN_O) || (dig_nxt != DIG_GAIN_O);

    ////////////////////////////////////////////////////////////////////////////
    // Gain registers update only on a finished average
    always_ff @(posedge CLK_I or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ANA_GAIN_O <= '1;                         // Start at full gain
            DIG_GAIN_O <= '1;
            AMP_AVG_O <= '0;
        end else if (state_r == ST_ACCUM && avg_done) begin
            ANA_GAIN_O <= ana_nxt;
            DIG_GAIN_O <= dig_nxt;
            AMP_AVG_O <= avg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settle wait: (code + 1) x 8 samples
    assign wait_target = glc_pkg::GLC_WAIT_STEP * (6'(act_r.wait_select) + 6'h01);

    // Loop sequencing; settings are sampled as each decision window opens
    always_ff @(posedge CLK_I or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_r <= ST_SETTLE;
            wait_cnt_r <= '0;
            act_r <= glc_pkg::GLC_CTRL_RESET;
            SETTLING_O <= 1'b1;
        end else begin
            case (state_r)
                ST_SETTLE: begin
                    if (SAMPLE_VLD_I) begin
                        if (wait_cnt_r + 6'h01 >= wait_target) begin
                            state_r <= ST_ACCUM;
                            wait_cnt_r <= '0;
                            act_r <= ctrl_r;
                            SETTLING_O <= 1'b0;
                        end else begin
                            wait_cnt_r <= wait_cnt_r + 6'h01;
                        end
                    end
                end
                ST_ACCUM: begin
                    if (avg_done) begin
                        if (step_made) begin          // Gain moved, wait again
                            state_r <= ST_SETTLE;
                            SETTLING_O <= 1'b1;
                        end else begin
                            act_r <= ctrl_r;
                        end
                    end
                end
                default: begin
                    state_r <= ST_SETTLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // OOK/ASK slicer: on when within the boundary below the average
    assign ook_db = glc_pkg::GLC_OOK_STEP_DB * (8'(act_r.filter_select) + 8'h01);
    assign ook_thr = {1'b0, 8'(AMP_AVG_O)} - {1'b0, ook_db};

    // Negative threshold (borrow) means any sample counts as on
    always_ff @(posedge CLK_I or negedge rst_n_s) begin
        if (!rst_n_s) begin
            OOK_BIT_O <= 1'b0;
        end else if (OOK_MODE_I && SAMPLE_VLD_I) begin
            OOK_BIT_O <= ook_thr[8] || ({1'b0, 8'(SAMPLE_I)} >= ook_thr);
        end
    end

endmodule : glc_gain_loop

// File: test/glc_gain_loop_assertions.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Pin-level watcher for the gain loop
module glc_checker #(
    parameter int AMP_W = 8, // Amplitude width
    parameter int ANA_W = 3, // Analogue width
    parameter int DIG_W = 3 // Digital width
) (
    input wire logic CLK_I, // Clock
    input wire logic RST_N_I, // Reset
    input wire logic REG_WE_I, // Write strobe
    input wire logic [5:0] REG_ADDR_I, // Address
    input wire logic [7:0] REG_WDATA_I, // Write data
    input wire logic [7:0] REG_RDATA_O, // Read data
    input wire logic SAMPLE_VLD_I, // Sample strobe
    input wire logic [AMP_W-1:0] SAMPLE_I, // Amplitude
    input wire logic OOK_MODE_I, // Slicer on
    input wire logic [ANA_W-1:0] ANA_GAIN_O, // Analogue gain
    input wire logic [DIG_W-1:0] DIG_GAIN_O, // Digital gain
    input wire logic [AMP_W-1:0] AMP_AVG_O, // Average
    input wire logic SETTLING_O, // Settle wait
    input wire logic OOK_BIT_O // Slicer bit
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic [5:0] scnt_r; // Samples seen while settling
    // Restarts once the wait ends; saturates so it never wraps
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scnt_r <= 6'h00;
        end else if (!SETTLING_O) begin
            scnt_r <= 6'h00;
        end else if (SAMPLE_VLD_I && scnt_r != 6'h3F) begin
            scnt_r <= scnt_r + 6'h01;
        end
    end
    ////////////////////////////////////////////////////////////
    chk_rd_other: assert property
        (REG_ADDR_I != 6'h1D |=> REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
    chk_rd_ctrl: assert property
        ((REG_WE_I && REG_ADDR_I == 6'h1D) ##1 (!REG_WE_I && REG_ADDR_I == 6'h1D)
        |=> REG_RDATA_O == $past(REG_WDATA_I, 2)) else $error("control readback wrong");
    chk_gain_settle: assert property
        (($changed(ANA_GAIN_O) || $changed(DIG_GAIN_O)) |-> SETTLING_O)
        else $error("gain moved without settle");
    chk_gain_single: assert property
        ($changed(ANA_GAIN_O) |-> $stable(DIG_GAIN_O)) else $error("both gains moved");
    chk_ana_step: assert property
        ($changed(ANA_GAIN_O) |-> (ANA_GAIN_O - $past(ANA_GAIN_O) == ANA_W'(1))
        || ($past(ANA_GAIN_O) - ANA_GAIN_O == ANA_W'(1))) else $error("gain jump over one");
    chk_settle_len: assert property
        ($fell(SETTLING_O) |-> scnt_r >= 6'h08 && scnt_r <= 6'h20)
        else $error("settle wait out of range");
    chk_ook_hold: assert property
        ($changed(OOK_BIT_O) |-> $past(OOK_MODE_I) && $past(SAMPLE_VLD_I))
        else $error("slicer moved without sample");
    chk_ook_high: assert property
        (OOK_MODE_I && SAMPLE_VLD_I && SAMPLE_I >= AMP_AVG_O |=> OOK_BIT_O)
        else $error("slicer missed loud sample");
    chk_avg_quiet: assert property
        ($changed(AMP_AVG_O) |-> !$past(SETTLING_O)) else $error("average during settle");
    cover property ($fell(SETTLING_O));
    cover property ($changed(ANA_GAIN_O));
    cover property ($changed(DIG_GAIN_O));
endmodule : glc_checker
bind glc_gain_loop glc_checker #(.AMP_W(AMP_W), .ANA_W(ANA_W), .DIG_W(DIG_W)) chk_u (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_WE_I(REG_WE_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .SAMPLE_VLD_I(SAMPLE_VLD_I),
    .SAMPLE_I(SAMPLE_I), .OOK_MODE_I(OOK_MODE_I), .ANA_GAIN_O(ANA_GAIN_O),
    .DIG_GAIN_O(DIG_GAIN_O), .AMP_AVG_O(AMP_AVG_O), .SETTLING_O(SETTLING_O),
    .OOK_BIT_O(OOK_BIT_O));

// File: test/glc_host_model.sv
`timescale 1ns/1ps
// Host side of the register port; calls start just after a falling edge
module glc_host_model (
    input wire logic clk_i, // Core clock
    input wire logic [7:0] rdata_i, // Read data
    output logic we_o, // Write strobe
    output logic [5:0] addr_o, // Address
    output logic [7:0] wdata_o // Write data
);
    initial begin
        we_o = 1'b0;
        addr_o = 6'h00;
        wdata_o = 8'h00;
    end
    // One-cycle strobe; data flipped after so stale bytes never look valid
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        we_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(negedge clk_i);
        we_o = 1'b0;
        wdata_o = ~d;
    endtask : wr
    // Read is address only; data lands one edge later
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        addr_o = a;
        @(negedge clk_i);
        d = rdata_i;
    endtask : rd
endmodule : glc_host_model

// File: test/glc_gain_loop_bench.sv
`timescale 1ns/1ps
module glc_gain_loop_bench;
    logic clk_i = 1'b0; // Core clock
    logic rst_n = 1'b0; // Reset, held low at start
    logic vld = 1'b0; // Sample strobe
    logic sync = 1'b0; // Sync found pulse
    logic idle = 1'b0; // Receiver idle
    logic ook = 1'b0; // Slicer enable
    logic [7:0] smp_d = 8'h00; // Sample amplitude
    logic we, settling, ookbit;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, avg;
    logic [2:0] ana_g, dig_g;
    int fail_count = 0;
    int tests_run = 0;
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    glc_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .we_o(we), .addr_o(addr),
        .wdata_o(wdata));
    glc_gain_loop dut_u (.CLK_I(clk_i), .RST_N_I(rst_n), .REG_WE_I(we), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SAMPLE_VLD_I(vld), .SAMPLE_I(smp_d),
        .SYNC_FOUND_I(sync), .RX_IDLE_I(idle), .OOK_MODE_I(ook), .ANA_GAIN_O(ana_g),
        .DIG_GAIN_O(dig_g), .AMP_AVG_O(avg), .SETTLING_O(settling), .OOK_BIT_O(ookbit));
    ////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] r;
        host_u.rd(a, r);
        cmp(r, e);
    endtask : chk_rd
    task automatic gains(input logic [2:0] a, input logic [2:0] d);
        cmp(8'(ana_g), 8'(a));
        cmp(8'(dig_g), 8'(d));
    endtask : gains
    // Strobe stays high between samples so it is never set twice in one step
    task automatic smp(input logic [7:0] a);
        vld = 1'b1;
        smp_d = a;
        @(negedge clk_i);
    endtask : smp
    // Feed until the wait ends (bounded), then one full averaging window
    task automatic win(input logic [7:0] a, input int n, output int s);
        s = 0;
        while (settling === 1'b1 && s < 64) begin
            smp(a);
            s++;
        end
        if (s >= 64) begin
            fail_count++;
            conclude();
        end
        repeat (n) smp(a);
        vld = 1'b0;
        smp_d = ~a;
        @(negedge clk_i);
    endtask : win
    // New settings only land at the next window, so run a dead-zone one
    task automatic cfg(input logic [7:0] d, input int n);
        int s;
        host_u.wr(6'h1D, d);
        chk_rd(6'h1D, d);
        win(8'h21, n, s);
    endtask : cfg
    ////////////////////////////////////////////////////////////
    initial begin
        logic [8:0] tv [3];
        int s;
        tv = '{9'h11E, 9'h01D, 9'h122};
        repeat (16) @(negedge clk_i);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_i);
        chk_rd(6'h1D, 8'h91);
        host_u.wr(6'h1E, 8'h55);
        chk_rd(6'h1E, 8'h00);
        chk_rd(6'h1D, 8'h91);
        win(8'h40, 16, s);
        cmp(8'(s), 8'h10);
        cmp(avg, 8'h40);
        gains(3'h6, 3'h7);
        cfg(8'h99, 16);
        win(8'h40, 16, s);
        gains(3'h6, 3'h6);
        cfg(8'h9D, 16);
        win(8'h40, 16, s);
        gains(3'h6, 3'h6);
        cmp(8'(settling), 8'h00);
        cfg(8'h95, 16);
        sync = 1'b1;
        @(negedge clk_i);
        sync = 1'b0;
        win(8'h40, 16, s);
        gains(3'h6, 3'h6);
        idle = 1'b1;
        @(negedge clk_i);
        idle = 1'b0;
        win(8'h40, 16, s);
        gains(3'h5, 3'h6);
        cfg(8'h91, 16);
        win(8'h24, 16, s);
        gains(3'h5, 3'h6);
        cfg(8'h11, 16);
        win(8'h24, 16, s);
        gains(3'h4, 3'h6);
        // Large dead zone, longest wait, 64-sample window and 16 dB boundary
        cfg(8'hF3, 64);
        win(8'h27, 64, s);
        gains(3'h4, 3'h6);
        win(8'h2A, 64, s);
        gains(3'h3, 3'h6);
        win(8'h21, 64, s);
        cmp(8'(s), 8'h20);
        ook = 1'b1;
        smp(8'h11);
        cmp(8'(ookbit), 8'h01);
        smp(8'h10);
        cmp(8'(ookbit), 8'h00);
        ook = 1'b0;
        // Two slicer samples already sit in this window: (0x21 + 62 x 0x40) / 64
        win(8'h40, 62, s);
        cmp(avg, 8'h3E);
        gains(3'h2, 3'h6);
        cfg(8'h10, 8);
        win(8'h22, 8, s);
        cmp(avg, 8'h22);
        ook = 1'b1;
        // Slicer edge sits 4 below the 0x22 average
        foreach (tv[i]) begin
            smp(tv[i][7:0]);
            cmp(8'(ookbit), 8'(tv[i][8]));
        end
        vld = 1'b0;
        conclude();
    end
endmodule : glc_gain_loop_bench
